// *** hw/stc_pkg.sv ***
// Shared constants and types for the scan test port pair
package stc_pkg;
  // Test port controller states
  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
    TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR,
    TAP_SHIFT_IR, TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
  } stc_tap_t;
  localparam int          IR_W        = 8;
  localparam logic [7:0]  IR_CAPTURE  = 8'h81;
  localparam logic [7:0]  IR_BYPASS   = 8'hff;
  localparam logic [7:0]  IR_RESET    = 8'hff;
  localparam int          DR_W        = 8;
  localparam logic        BYP_CAPTURE = 1'b0;
  // Link clock timing for the controller end
  localparam int          SYS_NS      = 50;
  localparam int          TCK_NS      = 400;
  // Shorter half periods miss tdo on its way back through two syncs
  localparam int          TCK_HALF_MIN = 6;
  localparam int          TCK_HALF_NOM = TCK_NS / (2 * SYS_NS);
  localparam int          TCK_HALF    = (TCK_HALF_NOM < TCK_HALF_MIN) ?
                                        TCK_HALF_MIN : TCK_HALF_NOM;
  localparam int          RESET_TMS   = 5;
  // Next state of the test port controller for one tms value
  function automatic stc_tap_t stc_next(input stc_tap_t s, input logic tms);
    unique case (s)
      TAP_RESET:    stc_next = tms ? TAP_RESET   : TAP_IDLE;
      TAP_IDLE:     stc_next = tms ? TAP_SEL_DR  : TAP_IDLE;
      TAP_SEL_DR:   stc_next = tms ? TAP_SEL_IR  : TAP_CAP_DR;
      TAP_CAP_DR:   stc_next = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR: stc_next = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR: stc_next = tms ? TAP_UPD_DR  : TAP_PAUSE_DR;
      TAP_PAUSE_DR: stc_next = tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR: stc_next = tms ? TAP_UPD_DR  : TAP_SHIFT_DR;
      TAP_UPD_DR:   stc_next = tms ? TAP_SEL_DR  : TAP_IDLE;
      TAP_SEL_IR:   stc_next = tms ? TAP_RESET   : TAP_CAP_IR;
      TAP_CAP_IR:   stc_next = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR: stc_next = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR: stc_next = tms ? TAP_UPD_IR  : TAP_PAUSE_IR;
      TAP_PAUSE_IR: stc_next = tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR: stc_next = tms ? TAP_UPD_IR  : TAP_SHIFT_IR;
      TAP_UPD_IR:   stc_next = tms ? TAP_SEL_DR  : TAP_IDLE;
    endcase
  endfunction
endpackage

// *** hw/stc_link_if.sv ***
// Four wire test port between controller and device
interface stc_link_if;
  logic tck;
  logic tms;
  logic tdi;
  logic tdo_o;
  logic tdo_oe;
  // Controller end drives clock, mode select and data in
  modport ctrl (output tck, output tms, output tdi,
                input tdo_o, input tdo_oe);
  // Device end drives data out and its enable
  modport dev (input tck, input tms, input tdi,
               output tdo_o, output tdo_oe);
endinterface

// *** hw/stc_sync.sv ***
// Two flip-flop synchroniser for pin levels
module stc_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Asynchronous level in, synchronised level out
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_q;
  // First stage feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      dout   <= '0;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule

// *** hw/stc_device.sv ***
// Device end: test port controller, instruction and bypass paths
module stc_device
  import stc_pkg::*;
(
  // System clock and reset
  input  wire logic          CLK_SYS,
  input  wire logic          RESET_N,
  // Test port
  stc_link_if.dev            LINK,
  // Normal-function data and captured test data
  input  wire logic [DR_W-1:0] DATA_IN,
  output logic      [DR_W-1:0] DATA_OUT,
  output logic      [IR_W-1:0] INSTR,
  output logic                 BYPASS_SEL,
  output logic      [3:0]      TAP_STATE
);
  typedef struct packed {
    logic            tck_q;
    stc_tap_t        tap_q;
    logic [IR_W-1:0] ir_sh_q;
    logic [IR_W-1:0] ir_q;
    logic            byp_q;
    logic [DR_W-1:0] dr_sh_q;
    logic [DR_W-1:0] dr_upd_q;
    logic [DR_W-1:0] din_q;
    logic            tdo_q;
    logic            tdo_oe_q;
  } stc_dev_st_t;
  stc_dev_st_t st_q;
  stc_dev_st_t st_d;
  logic [2:0]      pins_s;
  logic [DR_W-1:0] din_s;
  logic            tck_s;
  logic            tms_s;
  logic            tdi_s;
  logic            rise;
  logic            fall;
  logic            byp;
  // Capture and bypass patterns must match the register widths
  if ($bits(IR_CAPTURE) != IR_W || $bits(IR_BYPASS) != IR_W ||
      $bits(IR_RESET) != IR_W || DR_W < 2) begin : g_bad_width
    $error("stc_device: register widths do not match patterns");
  end
  // Pins cross into the system clock domain
  stc_sync #(.W(3)) u_sync_pins (
    .clk   (CLK_SYS),
    .rst_n (RESET_N),
    .din   ({LINK.tck, LINK.tms, LINK.tdi}),
    .dout  (pins_s)
  );
  stc_sync #(.W(DR_W)) u_sync_data (
    .clk   (CLK_SYS),
    .rst_n (RESET_N),
    .din   (DATA_IN),
    .dout  (din_s)
  );
  assign tck_s = pins_s[2];
  assign tms_s = pins_s[1];
  assign tdi_s = pins_s[0];
  // Edge finder on the synchronised test clock
  assign rise = tck_s & ~st_q.tck_q;
  assign fall = ~tck_s & st_q.tck_q;
  assign byp  = (st_q.ir_q == IR_BYPASS);
  // Next-state logic for the whole device end
  always_comb begin
    st_d       = st_q;
    st_d.tck_q = tck_s;
    if (rise) begin
      st_d.tap_q = stc_next(st_q.tap_q, tms_s);
      st_d.din_q = din_s;
      unique case (st_q.tap_q)
        TAP_CAP_IR:   st_d.ir_sh_q = IR_CAPTURE;
        TAP_SHIFT_IR: st_d.ir_sh_q = {tdi_s, st_q.ir_sh_q[IR_W-1:1]};
        TAP_CAP_DR: begin
          if (byp) begin
            st_d.byp_q = BYP_CAPTURE;
          end else begin
            st_d.dr_sh_q = st_q.din_q;
          end
        end
        TAP_SHIFT_DR: begin
          if (byp) begin
            st_d.byp_q = tdi_s;
          end else begin
            st_d.dr_sh_q = {tdi_s, st_q.dr_sh_q[DR_W-1:1]};
          end
        end
        // Other states leave the shift paths alone
        TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_SEL_IR,
        TAP_EXIT1_DR, TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR,
        TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR: ;
      endcase
    end
    if (fall) begin
      unique case (st_q.tap_q)
        TAP_SHIFT_IR: begin
          st_d.tdo_oe_q = 1'b1;
          st_d.tdo_q    = st_q.ir_sh_q[0];
        end
        TAP_SHIFT_DR: begin
          st_d.tdo_oe_q = 1'b1;
          st_d.tdo_q    = byp ? st_q.byp_q : st_q.dr_sh_q[0];
        end
        TAP_UPD_IR: begin
          st_d.ir_q     = st_q.ir_sh_q;
          st_d.tdo_oe_q = 1'b0;
        end
        TAP_UPD_DR: begin
          if (!byp) begin
            st_d.dr_upd_q = st_q.dr_sh_q;
          end
          st_d.tdo_oe_q = 1'b0;
        end
        TAP_RESET: begin
          st_d.ir_q     = IR_RESET;
          st_d.tdo_oe_q = 1'b0;
        end
        // Leaving the shift state releases the output
        TAP_EXIT1_IR, TAP_EXIT1_DR: begin
          st_d.tdo_oe_q = 1'b0;
        end
        TAP_IDLE, TAP_SEL_DR, TAP_SEL_IR, TAP_CAP_DR, TAP_CAP_IR,
        TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_PAUSE_IR, TAP_EXIT2_IR: begin
          st_d.tdo_oe_q = 1'b0;
        end
      endcase
    end
  end
  // State register
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      st_q          <= '0;
      st_q.tap_q    <= TAP_RESET;
      st_q.ir_q     <= IR_RESET;
      st_q.ir_sh_q  <= IR_CAPTURE;
    end else begin
      st_q <= st_d;
    end
  end
  // Outputs
  assign LINK.tdo_o  = st_q.tdo_q;
  assign LINK.tdo_oe = st_q.tdo_oe_q;
  assign DATA_OUT    = st_q.dr_upd_q;
  assign INSTR       = st_q.ir_q;
  assign BYPASS_SEL  = byp;
  assign TAP_STATE   = st_q.tap_q;
endmodule

// *** hw/stc_ctrl.sv ***
// Controller end: drives test clock and runs one IR and one DR scan
module stc_ctrl
  import stc_pkg::*;
#(
  parameter int HALF = TCK_HALF,
  parameter int W    = IR_W
) (
  // System clock and reset
  input  wire logic         CLK_SYS,
  input  wire logic         RESET_N,
  // Test port
  stc_link_if.ctrl          LINK,
  // Scan request and result
  input  wire logic         START,
  input  wire logic [W-1:0] IR_VAL,
  input  wire logic [W-1:0] DR_VAL,
  input  wire logic [7:0]   DR_LEN,
  output logic              BUSY,
  output logic              DONE,
  output logic      [W-1:0] IR_OUT,
  output logic      [W-1:0] DR_OUT
);
  // Divider and shifters serve only these parameter values
  if (HALF < TCK_HALF_MIN || HALF > 256 || W < 2 || W > 255) begin : g_bad
    $error("stc_ctrl: unsupported parameters");
  end
  typedef enum logic [1:0] {C_IDLE, C_RUN} stc_cst_t;
  typedef struct packed {
    stc_cst_t       st_q;
    logic [7:0]     div_q;
    logic           tck_q;
    logic           tms_q;
    logic           tdi_q;
    stc_tap_t       tap_q;
    logic [7:0]     cnt_q;
    logic           rst_walk_q;
    logic           ir_done_q;
    logic [W-1:0]   ir_q;
    logic [W-1:0]   dr_q;
    logic [W-1:0]   ir_in_q;
    logic [W-1:0]   dr_in_q;
    logic [7:0]     len_q;
    logic           done_q;
  } stc_ctl_st_t;
  stc_ctl_st_t s_q;
  stc_ctl_st_t s_d;
  logic tdo_s;
  logic tms_n;
  stc_sync #(.W(1)) u_sync_tdo (
    .clk   (CLK_SYS),
    .rst_n (RESET_N),
    .din   (LINK.tdo_o),
    .dout  (tdo_s)
  );
  // Mode select chosen for the next rising edge
  always_comb begin
    tms_n = 1'b1;
    unique case (s_q.tap_q)
      TAP_RESET:    tms_n = s_q.rst_walk_q;
      TAP_IDLE:     tms_n = 1'b1;
      TAP_SEL_DR:   tms_n = !s_q.ir_done_q || s_q.rst_walk_q;
      TAP_SEL_IR:   tms_n = s_q.rst_walk_q;
      TAP_CAP_IR, TAP_CAP_DR: tms_n = 1'b0;
      TAP_SHIFT_IR: tms_n = (s_q.cnt_q == 8'(W - 1));
      TAP_SHIFT_DR: tms_n = (s_q.cnt_q == s_q.len_q - 8'h01);
      TAP_EXIT1_DR, TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR,
      TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR:
                    tms_n = 1'b1;
    endcase
  end
  // Divider, walk and shift logic
  always_comb begin
    s_d        = s_q;
    s_d.done_q = 1'b0;
    if (s_q.st_q == C_IDLE) begin
      s_d.tck_q = 1'b0;
      if (START) begin
        s_d.st_q       = C_RUN;
        s_d.ir_q       = IR_VAL;
        s_d.dr_q       = DR_VAL;
        s_d.len_q      = (DR_LEN < 8'h02) ? 8'h02 : DR_LEN;
        s_d.tap_q      = TAP_RESET;
        s_d.rst_walk_q = 1'b0;
        s_d.ir_done_q  = 1'b0;
        s_d.cnt_q      = 8'h00;
        s_d.div_q      = 8'h00;
        s_d.tms_q      = 1'b0;
      end
    end else if (s_q.div_q == 8'(HALF - 1)) begin
      s_d.div_q = 8'h00;
      s_d.tck_q = ~s_q.tck_q;
      if (!s_q.tck_q) begin
        // Rising edge: device samples tms and tdi now
        s_d.tap_q = stc_next(s_q.tap_q, s_q.tms_q);
        s_d.cnt_q = s_q.cnt_q + 8'h01;
        if (s_q.tap_q == TAP_SHIFT_IR) begin
          s_d.ir_in_q = {tdo_s, s_q.ir_in_q[W-1:1]};
          s_d.ir_q    = s_q.ir_q >> 1;
        end
        if (s_q.tap_q == TAP_SHIFT_DR) begin
          s_d.dr_in_q = {tdo_s, s_q.dr_in_q[W-1:1]};
          s_d.dr_q    = s_q.dr_q >> 1;
        end
        if (s_q.tap_q == TAP_CAP_IR || s_q.tap_q == TAP_CAP_DR) begin
          s_d.cnt_q = 8'h00;
        end
        if (s_q.tap_q == TAP_UPD_IR) begin
          s_d.ir_done_q = 1'b1;
        end
        if (s_q.tap_q == TAP_UPD_DR) begin
          s_d.rst_walk_q = 1'b1;
        end
      end else begin
        // Falling edge: change tms and tdi
        s_d.tms_q = tms_n;
        if (s_q.tap_q == TAP_SHIFT_IR) begin
          s_d.tdi_q = s_q.ir_q[0];
        end else begin
          s_d.tdi_q = s_q.dr_q[0];
        end
        if (s_q.tap_q == TAP_SEL_DR) begin
          s_d.cnt_q = 8'h00;
        end
        // Scan ends with tck back low in Test-Logic-Reset, full high time
        if (s_q.tap_q == TAP_RESET && s_q.rst_walk_q) begin
          s_d.st_q   = C_IDLE;
          s_d.done_q = 1'b1;
        end
      end
    end else begin
      s_d.div_q = s_q.div_q + 8'h01;
    end
  end
  // State register
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      s_q       <= '0;
      s_q.st_q  <= C_IDLE;
      s_q.tap_q <= TAP_RESET;
      s_q.tms_q <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end
  // Outputs
  assign LINK.tck = s_q.tck_q;
  assign LINK.tms = s_q.tms_q;
  assign LINK.tdi = s_q.tdi_q;
  assign BUSY     = (s_q.st_q == C_RUN);
  assign DONE     = s_q.done_q;
  assign IR_OUT   = s_q.ir_in_q;
  assign DR_OUT   = s_q.dr_in_q;
endmodule

// *** tb/stc_asserts.sv ***
// Checker for the four wire test port timing
module stc_asserts #(
  parameter int HALF = 6
) (
  // System clock and reset
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  // Test port wires
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic tdo_o,
  input wire logic tdo_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] fall_q;
  logic [3:0] high_q;
  logic       tck_q;
  logic       tms_q;
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESET_N);
  // Cycles since tck fell, tck high time, tms seen at last tck rise
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      fall_q <= 4'hf;
      high_q <= 4'h0;
      tck_q  <= 1'b0;
      tms_q  <= 1'b1;
    end else begin
      tck_q  <= tck;
      high_q <= tck ? high_q + 4'h1 : 4'h0;
      if (tck_q && !tck)
        fall_q <= 4'h0;
      else if (fall_q != 4'hf)
        fall_q <= fall_q + 4'h1;
      if (!tck_q && tck)
        tms_q <= tms;
    end
  end
  // Fall of tck while driving after an exit step
  sequence s_exit_fall;
    $fell(tck) ##0 (tdo_oe && tms_q);
  endsequence
  sequence s_release;
    ##[1:6] !tdo_oe;
  endsequence
  AST_TDO_AT_FALL: assert property (($changed(tdo_oe) ||
    (tdo_oe && $changed(tdo_o))) |-> fall_q inside {[1:6]})
    else $error("tdo moved away from a tck fall");
  AST_TMS_LOW: assert property ($changed(tms) |-> !tck)
    else $error("tms moved while tck high");
  AST_TDI_LOW: assert property ($changed(tdi) |-> !tck)
    else $error("tdi moved while tck high");
  AST_TCK_HIGH: assert property ($fell(tck) |-> high_q == HALF)
    else $error("tck high time wrong");
  AST_OE_ON: assert property ($rose(tdo_oe) |-> !tms_q)
    else $error("tdo enabled outside a shift state");
  AST_OE_OFF: assert property ($fell(tdo_oe) |-> tms_q)
    else $error("tdo released outside an exit state");
  AST_OE_EXIT: assert property (s_exit_fall |-> s_release)
    else $error("tdo not released in exit state");
  AST_OE_SPAN: assert property ($rose(tdo_oe) |->
    ##[20:100] $fell(tdo_oe))
    else $error("shift window length wrong");
endmodule

// *** tb/scan_tap_timing_core_tb.sv ***
// Self-checking bench for the controller and device pair
module scan_tap_timing_core_tb
  import stc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int       HALF_TB = 6;
  localparam stc_tap_t ORDER[5] = '{TAP_IDLE, TAP_SEL_DR, TAP_SEL_IR,
                                    TAP_CAP_IR, TAP_SHIFT_IR};
  logic       clk_sys;
  logic       reset_n;
  logic       start;
  logic [7:0] ir_val;
  logic [7:0] dr_val;
  logic [7:0] dr_len;
  logic [7:0] data_in;
  logic [7:0] data_out;
  logic [7:0] instr;
  logic       bypass_sel;
  logic [3:0] tap_state;
  logic       busy;
  logic       done;
  logic [7:0] ir_out;
  logic [7:0] dr_out;
  logic [3:0] walk[$];
  int         n_mismatch;
  int         comparisons;
  int         seed;
  int         cycles;
  stc_link_if i_stc_link_if ();
  stc_device i_stc_device (.CLK_SYS(clk_sys), .RESET_N(reset_n),
    .LINK(i_stc_link_if), .DATA_IN(data_in), .DATA_OUT(data_out),
    .INSTR(instr), .BYPASS_SEL(bypass_sel), .TAP_STATE(tap_state));
  stc_ctrl #(.HALF(HALF_TB), .W(IR_W)) i_stc_ctrl (.CLK_SYS(clk_sys),
    .RESET_N(reset_n), .LINK(i_stc_link_if), .START(start),
    .IR_VAL(ir_val), .DR_VAL(dr_val), .DR_LEN(dr_len), .BUSY(busy),
    .DONE(done), .IR_OUT(ir_out), .DR_OUT(dr_out));
  stc_asserts #(.HALF(HALF_TB)) i_stc_asserts (.CLK_SYS(clk_sys),
    .RESET_N(reset_n), .tck(i_stc_link_if.tck), .tms(i_stc_link_if.tms),
    .tdi(i_stc_link_if.tdi), .tdo_o(i_stc_link_if.tdo_o),
    .tdo_oe(i_stc_link_if.tdo_oe));
  // Clock, hang limit and state walk log
  initial clk_sys = 1'b0;
  always #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 40000) begin
      n_mismatch++;
      $display("unexpected cycles: expected below %0d seen %0d", 40000,
        cycles);
      summarize();
    end
  end
  always @(tap_state) walk.push_back(tap_state);
  // Compare one value
  task automatic chk(input string what, input logic [7:0] e, logic [7:0] s);
    comparisons++;
    if (s !== e) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, e, s);
    end
  endtask
  // Bits read back: bypass gives 0 then earlier inputs, else pins
  function automatic logic [7:0] exp_dr(logic [7:0] ir, d, p, int n);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < n; i++)
      r[8-n+i] = (ir == IR_BYPASS) ? (i == 0 ? BYP_CAPTURE : d[i-1]) : p[i];
    return r;
  endfunction
  // Wait until a state or the end of the scan
  task automatic wait_for(input logic [3:0] st);
    bit hit;
    hit = 1'b0;
    for (int k = 0; k < 3000 && !hit; k++) begin
      @(posedge clk_sys);
      #2;
      hit = (st == 4'hf) ? (done === 1'b1) : (tap_state === st);
    end
    if (!hit) begin
      n_mismatch++;
      $display("unexpected wait: expected %h seen %h", st, tap_state);
    end
  endtask
  // Start one scan, then check it whole
  task automatic scan(input logic [7:0] ir, input logic [7:0] d, int n);
    logic [7:0] keep;
    keep = data_out;
    walk.delete();
    ir_val = ir;
    dr_val = d;
    dr_len = 8'(n);
    data_in = 8'($random(seed));
    start = 1'b1;
    @(posedge clk_sys);
    #2;
    start = 1'b0;
    chk("busy", 8'h01, {7'h0, busy});
    wait_for(TAP_SHIFT_DR);
    chk("instr", ir, instr);
    chk("bypass", {7'h0, ir == IR_BYPASS}, {7'h0, bypass_sel});
    wait_for(4'hf);
    chk("busy", 8'h00, {7'h0, busy});
    chk("ir_out", IR_CAPTURE, ir_out);
    chk("dr_out", exp_dr(ir, d, data_in, n),
      dr_out & (8'hff << (8 - n)));
    if (ir == IR_BYPASS)
      chk("data_out", keep, data_out);
    else
      chk("data_out", 8'({d, data_in} >> n), data_out);
    chk("state", {4'h0, TAP_RESET}, {4'h0, tap_state});
    chk("oe", 8'h00, {7'h0, i_stc_link_if.tdo_oe});
    for (int i = 0; i < 5; i++)
      chk("walk", {4'h0, ORDER[i]}, {4'h0, walk[i]});
  endtask
  // Print counts and verdict, then stop
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Main sequence
  initial begin
    {n_mismatch, comparisons, cycles} = '0;
    seed = 80;
    {reset_n, start, ir_val, dr_val, dr_len, data_in} = '0;
    repeat (12) @(posedge clk_sys);
    #2;
    reset_n = 1'b1;
    chk("instr", IR_RESET, instr);
    scan(IR_BYPASS, 8'h05, 3);
    scan(8'h3c, 8'ha5, 8);
    scan(IR_BYPASS, 8'h7e, 8);
    scan(8'h00, 8'h5a, 2);
    repeat (12)
      scan(($random(seed) & 1) ? IR_BYPASS : 8'($random(seed)),
        8'($random(seed)), 2 + {$random(seed)} % 7);
    ir_val = 8'h12;
    start = 1'b1;
    wait_for(TAP_SHIFT_IR);
    start = 1'b0;
    reset_n = 1'b0;
    #100;
    chk("state", {4'h0, TAP_RESET}, {4'h0, tap_state});
    chk("oe", 8'h00, {7'h0, i_stc_link_if.tdo_oe});
    chk("instr", IR_RESET, instr);
    @(posedge clk_sys);
    #2;
    reset_n = 1'b1;
    scan(8'hc3, 8'h96, 8);
    summarize();
  end
endmodule
